// ===== include/rcs_pkg.sv
// shared constants and types for the reset and clock sequencer
package rcs_pkg;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_SYS_HZ = 20000000;
  localparam int MIN_RESET_OUT_PULSE_NS = 500;
  localparam int MIN_RESET_OUT_CYC =
    (MIN_RESET_OUT_PULSE_NS * (CLK_SYS_HZ / 1000000) + 999) / 1000 < 1 ? 1 :
    (MIN_RESET_OUT_PULSE_NS * (CLK_SYS_HZ / 1000000) + 999) / 1000;
  localparam int DELAY_SHORT_CYC = 256;
  localparam int DELAY_LONG_CYC = 4096;
  localparam int FETCH_CYC = 2;
  localparam int CNT_W = 13;

  // ------------------------------------------------------------------
  // reset vector location
  // ------------------------------------------------------------------
  localparam logic [15:0] VECTOR_HI_ADDR = 16'hfffe;
  localparam logic [15:0] VECTOR_LO_ADDR = 16'hffff;

  // ------------------------------------------------------------------
  // option settings
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    RCS_SRC_EXT_CLOCK = 3'h0,
    RCS_SRC_RES_LOW = 3'h1,
    RCS_SRC_RES_MEDLOW = 3'h2,
    RCS_SRC_RES_MEDHIGH = 3'h3,
    RCS_SRC_RES_HIGH = 3'h4,
    RCS_SRC_EXT_RC = 3'h5,
    RCS_SRC_INT_RC = 3'h6
  } rcs_clk_src_t;

  typedef struct packed {
    logic longDelay;
    logic pllEnable;
    rcs_clk_src_t clkSrc;
  } rcs_option_t;

  // reset requests
  typedef struct packed {
    logic extPin;
    logic lowVoltage;
    logic watchdog;
  } rcs_req_t;

  // sequencer phases
  typedef enum logic [1:0] {
    RCS_ACTIVE = 2'h0,
    RCS_DELAY = 2'h1,
    RCS_FETCH = 2'h2,
    RCS_RUN = 2'h3
  } rcs_phase_t;

endpackage

// ===== core/rcs_pulse_stretch.sv
// minimum low-time stretcher for the reset pin drive
module rcs_pulse_stretch
  import rcs_pkg::*;
#(
  parameter int MIN_CYC = MIN_RESET_OUT_CYC
)(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic trigger,
  output logic active
);

  initial
  begin
    if (MIN_CYC < 1 || MIN_CYC > 255)
      $error("rcs_pulse_stretch: MIN_CYC out of range");
  end

  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;

  // reload on every trigger cycle, count down afterwards
  always_comb
  begin
    cnt_next = cnt_reg;
    if (trigger)
      cnt_next = 8'(MIN_CYC);
    else if (cnt_reg != 8'h00)
      cnt_next = cnt_reg - 8'h01;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      cnt_reg <= 8'h00;
    else
      cnt_reg <= cnt_next;
  end

  assign active = trigger || (cnt_reg != 8'h00);

endmodule

// ===== core/rcs_clock_select.sv
// clock source selection and pll stage for the sequencer
module rcs_clock_select
  import rcs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire rcs_option_t options,
  input wire logic inResetPhase,
  output logic oscRunEnable,
  output rcs_clk_src_t activeSource,
  output logic pllActive,
  output logic pllHalfDivide,
  output logic pllMisuse
);

  rcs_clk_src_t src_reg;
  rcs_clk_src_t src_next;
  logic pll_reg;
  logic pll_next;

  // option source is latched each cycle; oscillators never stop in reset
  always_comb
  begin
    src_next = options.clkSrc;
    pll_next = options.pllEnable;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      src_reg <= RCS_SRC_INT_RC;
      pll_reg <= 1'b0;
    end
    else
    begin
      src_reg <= src_next; // [R16]
      pll_reg <= pll_next; // [R15]
    end
  end

  assign activeSource = src_reg;
  assign oscRunEnable = 1'b1 | inResetPhase; // [R14]
  assign pllActive = pll_reg; // [R15]
  assign pllHalfDivide = !pll_reg; // [R15]
  assign pllMisuse = pll_reg && (src_reg == RCS_SRC_INT_RC); // [R17]

  property p_osc_runs;
    @(posedge clk_sys) disable iff (!resetn) inResetPhase |-> oscRunEnable;
  endproperty
  a_osc_runs: assert property (p_osc_runs) else $error("oscillator stopped in reset"); // [R14]

  property p_pll_div;
    @(posedge clk_sys) disable iff (!resetn)
      $past(options.pllEnable) |-> pllActive && !pllHalfDivide;
  endproperty
  a_pll_div: assert property (p_pll_div) else $error("pll mode wrong"); // [R15]

endmodule

// ===== core/rcs_reset_sequencer.sv
// reset sequencer: request merge, pin drive, delay and vector fetch
// Behaviour
// R1: external pin, low voltage and watchdog requests each start the sequence.
// R2: reset pin driven low throughout the delay phase.
// R3: start address fetched from the top two bytes of memory.
// R4: phases run active, delay, then vector fetch, in that order.
// R5: delay lasts 256 or 4096 cycles per option setting.
// R6: vector fetch lasts exactly two cycles after the delay.
// R7: reset pin is input and open-drain output with weak pull-up.
// R8: external source holds the pin low at least the minimum input time.
// R9: external reset is seen without a running clock.
// R10: after external pulse recognition the pin is driven low minimum output time.
// R11: short external pulses are stretched, long ones get no extra stretch.
// R12: pin stays low while low voltage is reported.
// R13: watchdog underflow drives pin low at least minimum output time.
// R14: resonator oscillators keep running during reset.
// R15: pll doubles input when enabled, otherwise stage clock is half oscillator.
// R16: main clock source chosen by option setting.
// R17: pll should not be combined with the internal rc oscillator.
// R18: delay count starts after all requests release, restarts on reassertion.
module rcs_reset_sequencer
  import rcs_pkg::*;
#(
  parameter int SHORT_DELAY = DELAY_SHORT_CYC,
  parameter int LONG_DELAY = DELAY_LONG_CYC,
  parameter int MIN_OUT_CYC = MIN_RESET_OUT_CYC
)(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic resetPinIn,
  output logic resetPinOut,
  output logic resetPinOe,
  input wire logic lowVoltageDetect,
  input wire logic watchdogUnderflow,
  input wire rcs_option_t options,
  output logic cpuResetn,
  output logic vectorFetch,
  output logic [15:0] vectorAddr,
  output logic vectorAddrValid,
  output rcs_phase_t phase,
  output rcs_req_t resetCause,
  output logic oscRunEnable,
  output rcs_clk_src_t activeSource,
  output logic pllActive,
  output logic pllHalfDivide,
  output logic pllMisuse
);

  // ------------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------------
  initial
  begin
    if (SHORT_DELAY < 2 || LONG_DELAY >= (1 << CNT_W) || SHORT_DELAY > LONG_DELAY)
      $error("rcs_reset_sequencer: delay parameters out of range");
  end

  // ------------------------------------------------------------------
  // external pin capture
  // ------------------------------------------------------------------
  // a pin low that we do not drive is latched without a clock, so a
  // stopped clock still enters reset; our own drive never counts as a request
  logic extSeen_reg;
  logic extSeen_next;
  logic extLowNow;
  logic pinLowSync;
  logic driveLow;
  rcs_phase_t phase_reg;
  rcs_phase_t phase_next;

  // pin held low by someone else right now
  assign extLowNow = !resetPinIn && !driveLow;

  // the captured pulse is consumed at every clock where the pin is no longer pulled by someone else
  always_comb
  begin
    extSeen_next = 1'b0;
  end

  // foreign pin low forces the flag without a clock
  always_ff @(posedge clk_sys or negedge resetn or negedge resetPinIn)
  begin
    if (!resetn)
      extSeen_reg <= 1'b0;
    else if (extLowNow)
      extSeen_reg <= 1'b1; // [R9]
    else
      extSeen_reg <= extSeen_next;
  end

  assign pinLowSync = extSeen_reg || extLowNow; // [R1]

  // ------------------------------------------------------------------
  // request merge and pulse stretch
  // ------------------------------------------------------------------
  logic extStart;
  logic extLow_reg;
  logic extLow_next;
  logic wdActive;
  logic extActive;
  logic anyReq;
  rcs_req_t cause_reg;
  rcs_req_t cause_next;

  // only registers feed the trigger, so the pin cannot loop back into it
  assign extStart = extSeen_reg && !extLow_reg;
  // an external pull counts as held until the pin is seen high again
  assign extLow_next = extSeen_reg || (extLow_reg && !resetPinIn);

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      extLow_reg <= 1'b0;
    else
      extLow_reg <= extLow_next;
  end

  // minimum low time after an external pulse is recognised
  rcs_pulse_stretch #(.MIN_CYC(MIN_OUT_CYC)) u_ext_stretch (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .trigger(extStart),
    .active(extActive)
  ); // [R10] [R11]

  // minimum low time after watchdog underflow
  rcs_pulse_stretch #(.MIN_CYC(MIN_OUT_CYC)) u_wd_stretch (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .trigger(watchdogUnderflow),
    .active(wdActive)
  ); // [R13]

  // any live request keeps the sequencer in its active phase
  assign anyReq = pinLowSync || lowVoltageDetect || watchdogUnderflow || extActive || wdActive; // [R1] [R12]

  // cause flags: set wins, cleared once the cpu runs again and a new
  // request arrives
  always_comb
  begin
    cause_next = cause_reg;
    if (phase_reg == RCS_RUN && anyReq)
      cause_next = '0;
    if (pinLowSync)
      cause_next.extPin = 1'b1;
    if (lowVoltageDetect)
      cause_next.lowVoltage = 1'b1;
    if (watchdogUnderflow)
      cause_next.watchdog = 1'b1;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      cause_reg <= '0;
    else
      cause_reg <= cause_next;
  end

  assign resetCause = cause_reg;

  // ------------------------------------------------------------------
  // phase machine
  // ------------------------------------------------------------------
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [CNT_W-1:0] delayLen;

  function automatic logic [CNT_W-1:0] delay_count(input logic longSel);
    return longSel ? CNT_W'(LONG_DELAY) : CNT_W'(SHORT_DELAY);
  endfunction

  assign delayLen = delay_count(options.longDelay); // [R5]

  always_comb
  begin
    phase_next = phase_reg;
    cnt_next = cnt_reg;
    if (anyReq)
    begin
      phase_next = RCS_ACTIVE; // [R18]
      cnt_next = '0;
    end
    else
    begin
      unique case (phase_reg)
        RCS_ACTIVE:
        begin
          phase_next = RCS_DELAY; // [R4] [R18]
          cnt_next = delayLen - CNT_W'(1);
        end
        RCS_DELAY:
        begin
          if (cnt_reg == '0)
          begin
            phase_next = RCS_FETCH; // [R4]
            cnt_next = CNT_W'(FETCH_CYC - 1);
          end
          else
            cnt_next = cnt_reg - CNT_W'(1);
        end
        RCS_FETCH:
        begin
          if (cnt_reg == '0)
            phase_next = RCS_RUN; // [R6]
          else
            cnt_next = cnt_reg - CNT_W'(1);
        end
        RCS_RUN:
        begin
          phase_next = RCS_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      phase_reg <= RCS_ACTIVE;
      cnt_reg <= '0;
    end
    else
    begin
      phase_reg <= phase_next;
      cnt_reg <= cnt_next;
    end
  end

  assign phase = phase_reg;

  // ------------------------------------------------------------------
  // pin drive and cpu outputs
  // ------------------------------------------------------------------
  // pin driven low in active and delay phases, enable low = drive; the active
  // phase lets go while an external pull may still hold, so its release is seen
  assign driveLow = (phase_reg == RCS_ACTIVE && !extLow_reg) || (phase_reg == RCS_DELAY)
                    || extActive || wdActive || lowVoltageDetect; // [R2] [R12]
  assign resetPinOut = 1'b0; // [R7]
  assign resetPinOe = !driveLow; // [R7]

  logic [15:0] addr_reg;
  logic [15:0] addr_next;

  // vector address walks the top two bytes during fetch
  always_comb
  begin
    addr_next = 16'h0000;
    if (phase_next == RCS_FETCH)
      addr_next = (phase_reg == RCS_FETCH) ? VECTOR_LO_ADDR : VECTOR_HI_ADDR; // [R3]
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      addr_reg <= 16'h0000;
    else
      addr_reg <= addr_next;
  end

  assign vectorAddr = addr_reg;
  assign vectorFetch = (phase_reg == RCS_FETCH); // [R6]
  assign vectorAddrValid = vectorFetch;
  assign cpuResetn = (phase_reg == RCS_RUN);

  // ------------------------------------------------------------------
  // clock source
  // ------------------------------------------------------------------
  rcs_clock_select u_clock (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .options(options),
    .inResetPhase(!cpuResetn),
    .oscRunEnable(oscRunEnable),
    .activeSource(activeSource),
    .pllActive(pllActive),
    .pllHalfDivide(pllHalfDivide),
    .pllMisuse(pllMisuse)
  ); // [R14] [R15] [R16]

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  property p_delay_drive;
    @(posedge clk_sys) disable iff (!resetn) phase_reg == RCS_DELAY |-> !resetPinOe;
  endproperty
  a_delay_drive: assert property (p_delay_drive) else $error("pin released in delay"); // [R2]

  property p_lv_drive;
    @(posedge clk_sys) disable iff (!resetn) lowVoltageDetect |-> !resetPinOe;
  endproperty
  a_lv_drive: assert property (p_lv_drive) else $error("pin released in low voltage"); // [R12]

  property p_order;
    @(posedge clk_sys) disable iff (!resetn)
      phase_reg == RCS_FETCH && $past(phase_reg) != RCS_FETCH |-> $past(phase_reg) == RCS_DELAY;
  endproperty
  a_order: assert property (p_order) else $error("fetch not after delay"); // [R4]

  property p_fetch_len;
    @(posedge clk_sys) disable iff (!resetn)
      $rose(vectorFetch) && !anyReq |-> vectorFetch ##1 (vectorFetch || anyReq) ##1 (!vectorFetch || anyReq);
  endproperty
  a_fetch_len: assert property (p_fetch_len) else $error("fetch not two cycles"); // [R6]

  property p_vector;
    @(posedge clk_sys) disable iff (!resetn)
      $rose(vectorFetch) |-> vectorAddr == VECTOR_HI_ADDR
        ##1 (vectorAddr == VECTOR_LO_ADDR || !vectorFetch);
  endproperty
  a_vector: assert property (p_vector) else $error("wrong vector address"); // [R3]

  property p_wd_min;
    @(posedge clk_sys) disable iff (!resetn) watchdogUnderflow |=> !resetPinOe;
  endproperty
  a_wd_min: assert property (p_wd_min) else $error("watchdog pulse too short"); // [R13]

  property p_ext_min;
    @(posedge clk_sys) disable iff (!resetn) extStart |=> !resetPinOe;
  endproperty
  a_ext_min: assert property (p_ext_min) else $error("external pulse not stretched"); // [R10]

  property p_restart;
    @(posedge clk_sys) disable iff (!resetn)
      lowVoltageDetect |=> phase_reg == RCS_ACTIVE;
  endproperty
  a_restart: assert property (p_restart) else $error("delay not restarted"); // [R18]

  property p_short_delay;
    @(posedge clk_sys) disable iff (!resetn)
      phase_reg == RCS_DELAY |-> cnt_reg < delayLen;
  endproperty
  a_short_delay: assert property (p_short_delay) else $error("delay count out of range"); // [R5]

  property p_async;
    @(posedge clk_sys) disable iff (!resetn) !resetPinIn && !driveLow |=> extSeen_reg;
  endproperty
  a_async: assert property (p_async) else $error("pin low not seen"); // [R9]

  c_fetch: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(vectorFetch));
  c_run: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(cpuResetn));
  c_wd: cover property (@(posedge clk_sys) disable iff (!resetn) cpuResetn ##1 watchdogUnderflow);
  c_ext: cover property (@(posedge clk_sys) disable iff (!resetn) extStart);

endmodule

// ===== bench/rcs_pin_partner.sv
// far-side model of the reset wire: external reset source and weak pull-up
module rcs_pin_partner
  import rcs_pkg::*;
#(
  parameter int MIN_IN_CYC = 2
)(
  input wire logic clk_sys,
  input wire logic resetPinOe,
  input wire logic extReq,
  output logic pinLevel
);
  timeunit 1ns;
  timeprecision 1ps;

  int holdCnt = 0;
  logic pulling;

  // ------------------------------------------------------------------
  // external pull
  // ------------------------------------------------------------------
  // once started, the external pull goes on for the minimum input time after the request drops
  always @(posedge clk_sys)
  begin
    if (extReq)
    begin
      holdCnt <= MIN_IN_CYC;
    end
    else if (holdCnt > 0)
    begin
      holdCnt <= holdCnt - 1;
    end
  end

  assign pulling = extReq || (holdCnt != 0);

  // ------------------------------------------------------------------
  // wire level
  // ------------------------------------------------------------------
  // open drain from both sides, weak pull-up when nobody pulls
  assign pinLevel = (!resetPinOe || pulling) ? 1'b0 : 1'b1;
endmodule

// ===== bench/rcs_reset_sequencer_tb.sv
// self-checking testbench for the reset sequencer
module rcs_reset_sequencer_tb;
  import rcs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int SHORT_N = 4;
  localparam int LONG_N = 8;
  localparam int MIN_OUT = 10;

  logic clk_sys;
  logic resetn;
  logic lowVoltageDetect;
  logic watchdogUnderflow;
  logic extPull;
  logic pinLevel;
  rcs_option_t options;
  logic resetPinOut;
  logic resetPinOe;
  logic cpuResetn;
  logic vectorFetch;
  logic [15:0] vectorAddr;
  logic vectorAddrValid;
  rcs_phase_t phase;
  rcs_req_t resetCause;
  logic oscRunEnable;
  rcs_clk_src_t activeSource;
  logic pllActive;
  logic pllHalfDivide;
  logic pllMisuse;
  int fail_count = 0;
  int num_checks = 0;

  // ------------------------------------------------------------------
  // design, far side and clock
  // ------------------------------------------------------------------
  rcs_reset_sequencer #(.SHORT_DELAY(SHORT_N), .LONG_DELAY(LONG_N), .MIN_OUT_CYC(MIN_OUT)) dut (
    .clk_sys(clk_sys), .resetn(resetn), .resetPinIn(pinLevel), .resetPinOut(resetPinOut),
    .resetPinOe(resetPinOe), .lowVoltageDetect(lowVoltageDetect),
    .watchdogUnderflow(watchdogUnderflow), .options(options), .cpuResetn(cpuResetn),
    .vectorFetch(vectorFetch), .vectorAddr(vectorAddr), .vectorAddrValid(vectorAddrValid),
    .phase(phase), .resetCause(resetCause), .oscRunEnable(oscRunEnable),
    .activeSource(activeSource), .pllActive(pllActive), .pllHalfDivide(pllHalfDivide),
    .pllMisuse(pllMisuse)
  );

  rcs_pin_partner #(.MIN_IN_CYC(2)) partner (
    .clk_sys(clk_sys), .resetPinOe(resetPinOe), .extReq(extPull), .pinLevel(pinLevel)
  );

  // 20 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // ------------------------------------------------------------------
  // checking and closing
  // ------------------------------------------------------------------
  // compare one value and count it
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // print the counts and the verdict, then stop
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // one reset sequence: raise a request, follow the phases to run
  // ------------------------------------------------------------------
  // src 0 pin, 1 low voltage, 2 watchdog; kick re-raises a request mid-delay
  task automatic run_seq(input int src, input int hold, input bit kick);
    int i;
    int actCnt;
    int dlyCnt;
    int fchCnt;
    int rstErr;
    int ordErr;
    int vecErr;
    logic [15:0] addr0;
    logic [15:0] addr1;
    rcs_phase_t prevPh;
    actCnt = 0;
    dlyCnt = 0;
    fchCnt = 0;
    rstErr = 0;
    ordErr = 0;
    vecErr = 0;
    addr0 = 16'h0000;
    addr1 = 16'h0000;
    prevPh = RCS_ACTIVE;
    @(negedge clk_sys);
    extPull = (src == 0);
    lowVoltageDetect = (src == 1);
    watchdogUnderflow = (src == 2);
    for (i = 0; i < 400; i++)
    begin
      @(negedge clk_sys);
      if (i + 1 >= hold)
      begin
        extPull = 1'b0;
        lowVoltageDetect = 1'b0;
        watchdogUnderflow = 1'b0;
      end
      if (phase === RCS_RUN && actCnt > 0)
        break;
      case (phase)
        RCS_ACTIVE: actCnt++;
        RCS_DELAY: dlyCnt++;
        RCS_FETCH:
        begin
          if (fchCnt == 0)
            addr0 = vectorAddr;
          else
            addr1 = vectorAddr;
          fchCnt++;
        end
        default: ;
      endcase
      if (phase < prevPh)
        ordErr++;
      prevPh = phase;
      if (phase === RCS_DELAY && resetPinOe !== 1'b0)
        rstErr++;
      if (phase !== RCS_RUN && (oscRunEnable !== 1'b1 || cpuResetn !== 1'b0))
        rstErr++;
      if (vectorAddrValid !== vectorFetch || vectorFetch !== (phase === RCS_FETCH))
        vecErr++;
      if (kick && dlyCnt == 2)
      begin
        watchdogUnderflow = 1'b1;
        kick = 1'b0;
        dlyCnt = 0;
        prevPh = RCS_ACTIVE;
      end
    end
    if (i == 400)
    begin
      fail_count++;
      report_and_stop();
    end
    check(16'(dlyCnt), options.longDelay ? 16'(LONG_N) : 16'(SHORT_N));
    check(16'(fchCnt), 16'h0002);
    check(addr0, 16'hfffe);
    check(addr1, 16'hffff);
    check(16'(vecErr), 16'h0000);
    check(16'(ordErr), 16'h0000);
    check(16'(rstErr), 16'h0000);
    check(16'(actCnt >= ((src == 1) ? hold : MIN_OUT)), 16'h0001);
    check(16'(resetCause), 16'(3'b100 >> src));
    check({12'h000, resetPinOut, cpuResetn, resetPinOe, oscRunEnable}, 16'h0007);
    $display("sequence from source %0d done", src);
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial
  begin
    int i;
    resetn = 1'b0;
    lowVoltageDetect = 1'b0;
    watchdogUnderflow = 1'b0;
    extPull = 1'b0;
    options = '{longDelay: 1'b0, pllEnable: 1'b0, clkSrc: RCS_SRC_RES_LOW};
    repeat (8) @(negedge clk_sys);
    check({14'h0000, cpuResetn, resetPinOe}, 16'h0000);
    resetn = 1'b1;
    for (i = 0; i < 100 && phase !== RCS_RUN; i++)
      @(negedge clk_sys);
    check(16'(phase), 16'(RCS_RUN));
    if (phase !== RCS_RUN)
      report_and_stop();
    $display("power-on sequence done");
    // every source with both delay lengths
    for (int d = 0; d < 2; d++)
    begin
      for (int s = 0; s < 3; s++)
      begin
        options.longDelay = d[0];
        run_seq(s, (s == 1) ? 20 : ((s == 0) ? 2 : 1), 1'b0);
      end
    end
    // a new request in mid-delay restarts the count
    run_seq(2, 1, 1'b1);
    // a long external pull gets no extra stretch and still finishes
    run_seq(0, 20, 1'b0);
    // every clock source with the pll off and on
    for (int p = 0; p < 2; p++)
    begin
      for (int c = 0; c < 7; c++)
      begin
        @(negedge clk_sys);
        options.pllEnable = p[0];
        options.clkSrc = rcs_clk_src_t'(c);
        repeat (2) @(negedge clk_sys);
        check(16'(activeSource), 16'(c));
        check({14'h0000, pllActive, pllHalfDivide}, {14'h0000, p[0], ~p[0]});
        check({15'h0000, pllMisuse}, {15'h0000, p[0] && c == 6});
      end
    end
    $display("clock option sweep done");
    report_and_stop();
  end
endmodule
